// ===== logic/rx_port_register_paging.sv
`timescale 1ns/1ps
// Operation
// - two receive ports, single or dual operation
// - port control register holds per-port enables
// - port enables writable only from local controller
// - separate private register copy per port
// - page select chooses private copy target
// - page select shows own port by default
// - programmable 7-bit address reaches port directly
// - port address also reaches shared registers
module rx_port_register_paging
  import rx_paging_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter logic [6:0] MAIN_ADDR = MAIN_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_remote,
  input wire logic [DEV_AW-1:0] acc_dev_addr,
  input wire logic [REG_AW-1:0] acc_reg_addr,
  input wire logic [DW-1:0] acc_wdata,
  input wire logic [PORTS-1:0] port_status_raw,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic [DW-1:0] rsp_data,
  output logic [PORTS-1:0] port_enable,
  output logic [PORTS*DW-1:0] port_ctl0,
  output logic [PORTS*DW-1:0] port_ctl1
);

  if (PORTS != 2) begin : g_check
    $error("page select encodes exactly two ports");
  end

  logic [DW-1:0] port_ctl;
  logic [DW-1:0] page_sel;
  logic [DW-1:0] port_addr [PORTS];
  logic [DW-1:0] priv_ctl0 [PORTS];
  logic [DW-1:0] priv_ctl1 [PORTS];
  logic [PORTS-1:0] sts_meta;
  logic [PORTS-1:0] sts_sync;

  function automatic logic is_private(input logic [REG_AW-1:0] a);
    return (a == OFS_PRIV_STS) || (a == OFS_PRIV_CTL0) || (a == OFS_PRIV_CTL1);
  endfunction : is_private

  // address decode: the main address or an enabled per-port address
  logic main_hit;
  logic [PORTS-1:0] port_hit;
  logic any_port_hit;
  logic hit;
  logic tgt;
  logic take;
  logic wr;

  always_comb begin
    main_hit = (acc_dev_addr == MAIN_ADDR);
    any_port_hit = 1'b0;
    tgt = page_sel[PAGE_PORT_BIT];
    for (int i = 0; i < PORTS; i++) begin
      port_hit[i] = port_addr[i][ADDR_EN_BIT] &&
                    (acc_dev_addr == port_addr[i][DW-1:ADDR_LSB]);
    end
    // scanning downwards lets the lowest matching port win; a port address equal to
    // the main address still routes as that port, so the page is ignored for it
    for (int i = PORTS - 1; i >= 0; i--) begin
      if (port_hit[i]) begin
        any_port_hit = 1'b1;
        tgt = 1'(i);
      end
    end
    hit = main_hit || any_port_hit;
    take = ce && acc_valid && hit;
    wr = take && acc_write;
  end

  // status pins arrive from the receiver analog domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_meta <= '0;
      sts_sync <= '0;
    end else if (ce) begin
      sts_meta <= port_status_raw;
      sts_sync <= sts_meta;
    end
  end

  // enables come only from the local side; the remote link cannot stop a port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_ctl <= PORT_CTL_RESET;
    end else if (wr && !acc_remote && acc_reg_addr == OFS_PORT_CTL) begin
      port_ctl <= acc_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_sel <= PAGE_SEL_RESET;
    end else if (wr && acc_reg_addr == OFS_PAGE_SEL) begin
      page_sel <= acc_wdata;
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        port_addr[p] <= PORT_ADDR_RESET;
      end else if (wr && acc_reg_addr == OFS_PORT_ADDR0 + 8'(p)) begin
        port_addr[p] <= acc_wdata;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        priv_ctl0[p] <= PRIV_CTL_RESET;
        priv_ctl1[p] <= PRIV_CTL_RESET;
      end else if (wr && tgt == 1'(p) && is_private(acc_reg_addr)) begin
        if (acc_reg_addr == OFS_PRIV_CTL0) begin
          priv_ctl0[p] <= acc_wdata;
        end
        if (acc_reg_addr == OFS_PRIV_CTL1) begin
          priv_ctl1[p] <= acc_wdata;
        end
      end
    end

    assign port_ctl0[p*DW +: DW] = priv_ctl0[p];
    assign port_ctl1[p*DW +: DW] = priv_ctl1[p];
  end

  assign port_enable = port_ctl[PORTS-1:0];

  logic [DW-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    case (acc_reg_addr)
      OFS_PORT_CTL: next_rdata = port_ctl;
      // through a port address the page reads back as that port
      OFS_PAGE_SEL: next_rdata = any_port_hit ? {page_sel[DW-1:1], tgt} : page_sel;
      OFS_PORT_ADDR0: next_rdata = port_addr[0];
      OFS_PORT_ADDR1: next_rdata = port_addr[1];
      OFS_PRIV_STS: next_rdata = {{(DW-1){1'b0}}, sts_sync[tgt]};
      OFS_PRIV_CTL0: next_rdata = priv_ctl0[tgt];
      OFS_PRIV_CTL1: next_rdata = priv_ctl1[tgt];
      default: next_rdata = '0;
    endcase
  end

  // answer one cycle after every access seen, ack only when addressed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_data <= '0;
    end else if (ce) begin
      rsp_valid <= acc_valid;
      rsp_ack <= acc_valid && hit;
      rsp_data <= (acc_valid && hit && !acc_write) ? next_rdata : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence local_ctl_write;
    wr && !acc_remote && acc_reg_addr == OFS_PORT_CTL;
  endsequence
  sequence priv_write_main;
    wr && main_hit && !any_port_hit && acc_reg_addr == OFS_PRIV_CTL0;
  endsequence
  sequence priv_write_port1;
    wr && port_hit[1] && !port_hit[0] && acc_reg_addr == OFS_PRIV_CTL0;
  endsequence
  sequence priv_read_port1;
    take && !acc_write && port_hit[1] && !port_hit[0] && acc_reg_addr == OFS_PRIV_CTL0;
  endsequence
  sequence page_write;
    wr && acc_reg_addr == OFS_PAGE_SEL;
  endsequence

  ctl_local_write_a: assert property (local_ctl_write |=>
    port_enable == $past(acc_wdata[PORTS-1:0]))
    else $error("local enable write lost");
  ctl_remote_block_a: assert property (
    wr && acc_remote && acc_reg_addr == OFS_PORT_CTL |=> $stable(port_enable))
    else $error("remote write changed enables");
  enable_mirror_a: assert property (
    !(wr && !acc_remote && acc_reg_addr == OFS_PORT_CTL) |=> $stable(port_enable))
    else $error("enables changed without a local write");
  page_route_a: assert property (
    priv_write_main ##0 (page_sel[PAGE_PORT_BIT] == 1'b1) |=>
    priv_ctl0[1] == $past(acc_wdata)) else $error("page routing wrong");
  other_copy_a: assert property (
    priv_write_main ##0 (page_sel[PAGE_PORT_BIT] == 1'b1) |=>
    $stable(priv_ctl0[0])) else $error("wrong copy changed");
  port_route_a: assert property (
    priv_write_port1 ##0 (page_sel[PAGE_PORT_BIT] == 1'b0) |=>
    priv_ctl0[1] == $past(acc_wdata) && $stable(priv_ctl0[0]))
    else $error("port address did not override page");
  page_default_a: assert property (
    take && !acc_write && port_hit[1] && !port_hit[0] && acc_reg_addr == OFS_PAGE_SEL |=>
    rsp_data[PAGE_PORT_BIT] == 1'b1) else $error("page not showing own port");
  shared_via_port_a: assert property (
    take && !acc_write && any_port_hit && acc_reg_addr == OFS_PORT_CTL |=>
    rsp_ack && rsp_data == $past(port_ctl)) else $error("shared read via port address failed");
  port_read_a: assert property (priv_read_port1 |=>
    rsp_data == $past(priv_ctl0[1]))
    else $error("port address read wrong copy");
  page_store_a: assert property (page_write |=>
    page_sel == $past(acc_wdata))
    else $error("page write lost");
  port_answer_a: assert property (ce && acc_valid && any_port_hit |=>
    rsp_valid && rsp_ack)
    else $error("port address not answered");
  miss_answer_a: assert property (ce && acc_valid && !hit |=>
    rsp_valid && !rsp_ack && rsp_data == '0)
    else $error("unmatched access answered");
  freeze_hold_a: assert property (!ce |=>
    $stable(port_ctl0) && $stable(port_ctl1) && $stable(rsp_valid))
    else $error("state moved while clock enable low");

endmodule : rx_port_register_paging

// ===== logic/rx_paging_pkg.sv
package rx_paging_pkg;
  localparam int NUM_PORTS = 2;
  localparam int DW = 8;
  localparam int DEV_AW = 7;
  localparam int REG_AW = 8;
  // shared registers
  localparam logic [7:0] OFS_PORT_CTL = 8'h0c;
  localparam logic [7:0] OFS_PAGE_SEL = 8'h4c;
  localparam logic [7:0] OFS_PORT_ADDR0 = 8'h70;
  localparam logic [7:0] OFS_PORT_ADDR1 = 8'h71;
  // port-private registers, one copy per port
  localparam logic [7:0] OFS_PRIV_STS = 8'h4d;
  localparam logic [7:0] OFS_PRIV_CTL0 = 8'h4e;
  localparam logic [7:0] OFS_PRIV_CTL1 = 8'h4f;
  // reset values
  localparam logic [7:0] PORT_CTL_RESET = 8'h03;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] PORT_ADDR_RESET = 8'h00;
  localparam logic [7:0] PRIV_CTL_RESET = 8'h00;
  // field positions
  localparam int PAGE_PORT_BIT = 0;
  localparam int ADDR_EN_BIT = 0;
  localparam int ADDR_LSB = 1;
  localparam logic [6:0] MAIN_ADDR_DEFAULT = 7'h30;
endpackage : rx_paging_pkg

// ===== sim/i2c_ctrl_model.sv
`timescale 1ns/1ps
module i2c_ctrl_model (
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [7:0] rsp_data,
  output logic acc_valid,
  output logic acc_write,
  output logic acc_remote,
  output logic [6:0] acc_dev_addr,
  output logic [7:0] acc_reg_addr,
  output logic [7:0] acc_wdata
);
  initial {acc_valid, acc_write, acc_remote, acc_dev_addr, acc_reg_addr, acc_wdata} = '0;
  // one byte per request; cmd is {write, remote, device address, register offset}
  task automatic xfer(input logic [16:0] cmd, input logic [7:0] wd, output logic [9:0] rsp);
    int n;
    @(negedge clk);
    {acc_write, acc_remote, acc_dev_addr, acc_reg_addr} = cmd;
    acc_wdata = wd;
    acc_valid = 1'b1;
    @(negedge clk);
    acc_valid = 1'b0;
    // stale write data is not left on the bus
    acc_wdata = ~wd;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    rsp = {rsp_valid, rsp_ack, rsp_data};
  endtask : xfer
endmodule : i2c_ctrl_model

// ===== sim/rx_port_register_paging_tb.sv
`timescale 1ns/1ps
module rx_port_register_paging_tb;
  import rx_paging_pkg::*;
  typedef struct packed {logic [16:0] cmd; logic [7:0] wd; logic [9:0] exp;} row_t;
  localparam logic [6:0] M = MAIN_ADDR_DEFAULT;
  localparam logic [6:0] A0 = 7'h41;
  localparam logic [6:0] A1 = 7'h42;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [1:0] sts = 2'b10;
  logic acc_valid, acc_write, acc_remote, rsp_valid, rsp_ack;
  logic [6:0] acc_dev_addr;
  logic [7:0] acc_reg_addr, acc_wdata, rsp_data;
  logic [1:0] port_enable;
  logic [15:0] port_ctl0, port_ctl1;
  logic [9:0] rsp;
  int fails = 0, check_count = 0;
  row_t rows[26] = '{
    '{{2'b00, M, OFS_PORT_CTL}, 8'h00, 10'h303},
    '{{2'b00, M, OFS_PAGE_SEL}, 8'h00, 10'h300},
    '{{2'b10, M, OFS_PRIV_CTL0}, 8'ha5, 10'h300},
    '{{2'b10, M, OFS_PAGE_SEL}, 8'h01, 10'h300},
    '{{2'b10, M, OFS_PRIV_CTL0}, 8'h5a, 10'h300},
    '{{2'b00, M, OFS_PRIV_CTL0}, 8'h00, 10'h35a},
    '{{2'b10, M, OFS_PAGE_SEL}, 8'h00, 10'h300},
    '{{2'b00, M, OFS_PRIV_CTL0}, 8'h00, 10'h3a5},
    '{{2'b10, M, OFS_PORT_ADDR0}, 8'h83, 10'h300},
    '{{2'b10, M, OFS_PORT_ADDR1}, 8'h85, 10'h300},
    '{{2'b00, A1, OFS_PRIV_CTL0}, 8'h00, 10'h35a},
    '{{2'b00, A0, OFS_PRIV_CTL0}, 8'h00, 10'h3a5},
    '{{2'b10, A1, OFS_PRIV_CTL0}, 8'h6b, 10'h300},
    '{{2'b10, A0, OFS_PRIV_CTL1}, 8'h3c, 10'h300},
    '{{2'b00, A0, OFS_PRIV_CTL1}, 8'h00, 10'h33c},
    '{{2'b00, A1, OFS_PORT_CTL}, 8'h00, 10'h303},
    '{{2'b00, A1, OFS_PAGE_SEL}, 8'h00, 10'h301},
    '{{2'b00, A1, OFS_PRIV_STS}, 8'h00, 10'h301},
    '{{2'b00, A0, OFS_PRIV_STS}, 8'h00, 10'h300},
    '{{2'b11, M, OFS_PORT_CTL}, 8'h00, 10'h300},
    '{{2'b00, M, OFS_PORT_CTL}, 8'h00, 10'h303},
    '{{2'b00, 7'h55, OFS_PORT_CTL}, 8'h00, 10'h200},
    '{{2'b10, A1, OFS_PORT_CTL}, 8'h01, 10'h300},
    '{{2'b00, M, 8'h7f}, 8'h00, 10'h300},
    '{{2'b10, M, OFS_PORT_ADDR1}, 8'h84, 10'h300},
    '{{2'b00, A1, OFS_PORT_CTL}, 8'h00, 10'h200}};
  always #4 clk = ~clk;
  rx_port_register_paging u_rx_port_register_paging (.clk, .rst_n, .ce, .acc_valid, .acc_write,
    .acc_remote, .acc_dev_addr, .acc_reg_addr, .acc_wdata, .port_status_raw(sts), .rsp_valid,
    .rsp_ack, .rsp_data, .port_enable, .port_ctl0, .port_ctl1);
  i2c_ctrl_model u_i2c_ctrl_model (.clk, .rsp_valid, .rsp_ack, .rsp_data, .acc_valid,
    .acc_write, .acc_remote, .acc_dev_addr, .acc_reg_addr, .acc_wdata);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(negedge clk);
    chk({14'h0, port_enable}, 16'h0003);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      u_i2c_ctrl_model.xfer(rows[i].cmd, rows[i].wd, rsp);
      chk({6'h0, rsp}, {6'h0, rows[i].exp});
    end
    @(negedge clk);
    chk({15'h0, rsp_valid}, 16'h0000);
    chk({14'h0, port_enable}, 16'h0001);
    chk(port_ctl0, 16'h6ba5);
    chk(port_ctl1, 16'h003c);
    $display("test rows done");
    // a request while the clock enable is low must be dropped: no answer and no write
    ce = 1'b0;
    u_i2c_ctrl_model.xfer({2'b10, M, OFS_PRIV_CTL1}, 8'hff, rsp);
    chk({6'h0, rsp}, 16'h0000);
    ce = 1'b1;
    chk(port_ctl1, 16'h003c);
    $display("test clock enable done");
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk({port_ctl0[7:0], 6'h0, port_enable}, 16'h0003);
    rst_n = 1'b1;
    u_i2c_ctrl_model.xfer({2'b00, M, OFS_PORT_CTL}, 8'h00, rsp);
    chk({6'h0, rsp}, 16'h0303);
    $display("test reset done");
    test_done();
  end
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : rx_port_register_paging_tb
